// file: swiu_cfg.svh
// Constants of the sleep, wakeup and interrupt unit: offsets, positions, resets, timing.
`ifndef SWIU_CFG_SVH
`define SWIU_CFG_SVH

// Mode register values that steer a port B write.
`define SWIU_MODE_CMP      8'h18
`define SWIU_MODE_PEND     8'h19
`define SWIU_MODE_EDGE     8'h1A
`define SWIU_MODE_EN       8'h1B

// Reset values of the wakeup enable and edge select masks and of the pending flags.
`define SWIU_MASK_RST      8'hFF
`define SWIU_PEND_RST      8'h00

// Program counter targets.
`define SWIU_PC_W          12
`define SWIU_PC_TOP        12'hFFF
`define SWIU_PC_ISR        12'h000

// Position of the power down clock fuse and of the page select bits in status.
`define SWIU_FUSE_CLK_BIT  11
`define SWIU_PAGE_MASK     8'hE0

// Real-time counter values.
`define SWIU_REAL_TIME_COUNTER_TOP      8'hFF
`define SWIU_REAL_TIME_COUNTER_ONE      8'h01

// Watchdog tick period in ns, clock period in ns and the derived divider count.
`define SWIU_CLK_NS        100
`define SWIU_WDT_TICK_NS   10000
`define SWIU_WDT_DIV       (`SWIU_WDT_TICK_NS / `SWIU_CLK_NS)
`define SWIU_WDT_TOP       8'hFF

// Synchroniser width: eight port B pins plus the external reset pin.
`define SWIU_SYNC_W        9
`define SWIU_RSTPIN_BIT    8

`endif

// file: swiu_pkg.sv
// Types of the sleep, wakeup and interrupt unit.
`include "swiu_cfg.svh"
package swiu_pkg;

   // Operating mode of the core.
   typedef enum logic {
      ST_RUN,
      ST_SLEEP
   } swiu_mode_e;

   // Synchroniser state.
   typedef struct packed {
      logic [`SWIU_SYNC_W-1:0] s1;
      logic [`SWIU_SYNC_W-1:0] s2;
      logic [`SWIU_SYNC_W-1:0] s3;
   } swiu_sync_s;

   // Watchdog state.
   typedef struct packed {
      logic [6:0] div;
      logic [7:0] cnt;
      logic       ovf;
   } swiu_wd_s;

   // Main controller state.
   typedef struct packed {
      swiu_mode_e              mode;
      logic [7:0]              en;
      logic [7:0]              edge_sel;
      logic [7:0]              pend;
      logic [7:0]              real_time_counter;
      logic                    rov;
      logic                    int_en;
      logic                    in_isr;
      logic [`SWIU_PC_W-1:0]   stack_pc;
      logic [7:0]              sh_fsr;
      logic [7:0]              sh_status;
      logic [7:0]              sh_mode;
      logic [7:0]              sh_w;
      logic                    pc_load;
      logic [`SWIU_PC_W-1:0]   pc_val;
      logic                    restore;
      logic                    int_entry;
      logic [7:0]              fsr_out;
      logic [7:0]              status_out;
      logic [7:0]              mode_out;
      logic [7:0]              w_out;
      logic                    xchg_valid;
      logic [7:0]              xchg_data;
      logic                    to;
      logic                    pd;
      logic                    osc_on;
      logic                    halt;
   } swiu_top_s;

endpackage

// file: swiu_wd_if.sv
// Link between the controller and the watchdog counter.
`timescale 1ns/10ps
interface swiu_wd_if;
   logic enable;
   logic clear;
   logic overflow;

   modport ctrl (output enable, output clear, input overflow);
   modport wdog (input enable, input clear, output overflow);
endinterface

// file: swiu_sync.sv
// Three flip-flop synchroniser for the port B pins and the external reset pin.
`timescale 1ns/10ps
`include "swiu_cfg.svh"
module swiu_sync (
   // Clock and reset.
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Pins from outside the clock domain.
   input  wire logic [`SWIU_SYNC_W-1:0] async_i,
   // Second and third stage.
   output logic      [`SWIU_SYNC_W-1:0] sync_o,
   output logic      [`SWIU_SYNC_W-1:0] dly_o
);
   swiu_pkg::swiu_sync_s q;
   swiu_pkg::swiu_sync_s d;

   // Shift the pins through three stages; only stage two reads stage one.
   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   // Register the stages; reset to all ones, the idle level of pulled-up pins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '1;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;
   assign dly_o  = q.s3;
endmodule // swiu_sync

// file: swiu_wdog.sv
// Watchdog counter with its tick divider.
`timescale 1ns/10ps
`include "swiu_cfg.svh"
module swiu_wdog (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control link.
   swiu_wd_if.wdog   wd
);
   swiu_pkg::swiu_wd_s q;
   swiu_pkg::swiu_wd_s d;
   logic               tick;

   // Count ticks while enabled; a clear restarts both divider and counter.
   always_comb begin
      d     = q;
      d.ovf = 1'b0;
      tick  = (q.div == 7'(`SWIU_WDT_DIV - 1));
      if (wd.clear || !wd.enable) begin
         d.div = '0;
         d.cnt = '0;
      end else begin
         d.div = tick ? '0 : q.div + 7'h01;
         if (tick) begin
            d.cnt = q.cnt + 8'h01;
            d.ovf = (q.cnt == `SWIU_WDT_TOP);
         end
      end
   end

   // Register the watchdog state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign wd.overflow = q.ovf;
endmodule // swiu_wdog

// file: swiu_top.sv
// Power down control, port B wakeup and interrupt entry and return.
//
// Contract
// - Sleep instruction enters power down, halts execution.
// - In power down only enabled watchdog runs.
// - Sleep with watchdog: clear counter, set timeout, clear powerdown.
// - Exit on watchdog overflow, port B edge, reset pin.
// - Fuse bit 11 zero keeps oscillator running.
// - Enable mask bit zero enables its pin.
// - Edge select one means falling, zero rising.
// - Reset loads both masks with all ones.
// - Selected edge sets and holds pending bit.
// - Port B wakeup loads highest program address.
// - Mode selects register; pending and comparator exchange.
// - Outside power down pins are interrupt sources.
// - Counter rollover raises gated interrupt, sets flag.
// - Equal priority; interrupts off until return.
// - Entry pushes PC, shadows file, status, mode, W.
// - Page select bits cleared after status saved.
// - Interrupt entry point is address zero.
// - Return restores all and re-enables interrupts.
// - Edge during service pends, serviced after return.
`timescale 1ns/10ps
`include "swiu_cfg.svh"
module swiu_top (
   // Clock and reset.
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Pins.
   input  wire logic [7:0]            port_b_pins_i,
   input  wire logic                  external_reset_pin_n_i,
   // Configuration.
   input  wire logic [11:0]           extended_fuse_word_i,
   input  wire logic                  watchdog_enable_i,
   input  wire logic                  real_time_counter_int_enable_i,
   // Core instruction events.
   input  wire logic                  sleep_exec_i,
   input  wire logic                  wdt_clear_i,
   input  wire logic                  int_boundary_i,
   input  wire logic                  interrupt_return_i,
   input  wire logic                  interrupt_return_with_add_i,
   input  wire logic                  rollover_clear_i,
   // Core port write and register values.
   input  wire logic                  port_wr_i,
   input  wire logic [7:0]            mode_reg_i,
   input  wire logic [7:0]            w_reg_i,
   input  wire logic [7:0]            fsr_reg_i,
   input  wire logic [7:0]            status_reg_i,
   input  wire logic [`SWIU_PC_W-1:0] pc_i,
   input  wire logic [7:0]            comparator_result_i,
   // Program counter load.
   output logic                       pc_load_o,
   output logic      [`SWIU_PC_W-1:0] pc_value_o,
   // Interrupt entry and return.
   output logic                       int_entry_o,
   output logic                       restore_o,
   output logic      [7:0]            fsr_o,
   output logic      [7:0]            status_o,
   output logic      [7:0]            mode_o,
   output logic      [7:0]            w_o,
   // Exchange result of a pending or comparator write.
   output logic                       xchg_valid_o,
   output logic      [7:0]            xchg_data_o,
   // Register and flag views.
   output logic      [7:0]            wake_enable_mask_o,
   output logic      [7:0]            wake_edge_select_o,
   output logic      [7:0]            wake_pending_flags_o,
   output logic      [7:0]            real_time_counter_o,
   output logic                       counter_rollover_flag_o,
   output logic                       timeout_flag_o,
   output logic                       power_down_flag_o,
   // Power control.
   output logic                       power_down_oscillator_o,
   output logic                       halt_o
);

   swiu_pkg::swiu_top_s q;
   swiu_pkg::swiu_top_s d;

   logic [`SWIU_SYNC_W-1:0] pin_sync;
   logic [`SWIU_SYNC_W-1:0] pin_dly;
   logic [7:0]              rise;
   logic [7:0]              fall;
   logic [7:0]              hit;
   logic                    running;
   logic                    ext_pend;
   logic                    irq;
   logic                    rst_pin_low;
   logic                    wake;
   logic                    ret_any;
   logic                    sleep_wd;

   swiu_wd_if wd_link ();

   // Pins cross into the clock domain before any edge logic sees them.
   swiu_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({external_reset_pin_n_i, port_b_pins_i}),
      .sync_o  (pin_sync),
      .dly_o   (pin_dly)
   );

   // The watchdog runs in both modes when enabled.
   swiu_wdog u_wdog (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .wd    (wd_link)
   );

   // Watchdog control: the sleep instruction restarts the count.
   assign sleep_wd        = running && sleep_exec_i && watchdog_enable_i;
   assign wd_link.enable  = watchdog_enable_i;
   assign wd_link.clear   = wdt_clear_i || sleep_wd;

   // Decoded conditions shared by the next-state logic.
   assign running     = (q.mode == swiu_pkg::ST_RUN);
   assign rise        = pin_sync[7:0] & ~pin_dly[7:0];
   assign fall        = ~pin_sync[7:0] & pin_dly[7:0];
   assign hit         = (q.edge_sel & fall) | (~q.edge_sel & rise);
   assign ext_pend    = |(q.pend & ~q.en);
   assign rst_pin_low = !pin_sync[`SWIU_RSTPIN_BIT] && !pin_dly[`SWIU_RSTPIN_BIT];
   assign wake        = wd_link.overflow || ext_pend || rst_pin_low;
   assign ret_any     = interrupt_return_i || interrupt_return_with_add_i;

   // One shared request line: no source outranks another, and the enable
   // drops on entry so a second source waits for the return.
   assign irq = q.int_en && running &&
                (ext_pend || (q.rov && real_time_counter_int_enable_i));

   // Next-state logic for every register of the unit.
   always_comb begin
      d            = q;
      d.pc_load    = 1'b0;
      d.restore    = 1'b0;
      d.int_entry  = 1'b0;
      d.xchg_valid = 1'b0;

      // The counter only advances while instructions execute.
      if (running) begin
         d.real_time_counter = q.real_time_counter + `SWIU_REAL_TIME_COUNTER_ONE;
      end

      // Port writes steered by the mode register value.
      if (port_wr_i && running) begin
         case (mode_reg_i)
            `SWIU_MODE_PEND: begin
               d.pend       = w_reg_i;
               d.xchg_valid = 1'b1;
               d.xchg_data  = q.pend;
            end
            `SWIU_MODE_CMP: begin
               d.xchg_valid = 1'b1;
               d.xchg_data  = comparator_result_i;
            end
            `SWIU_MODE_EDGE: begin
               d.edge_sel = w_reg_i;
            end
            `SWIU_MODE_EN: begin
               d.en = w_reg_i;
            end
            default: begin
            end
         endcase
      end

      // A fresh edge wins over a write that clears its bit, in any mode,
      // including during a service routine.
      d.pend = d.pend | hit;

      // Rollover flag: a rollover in the clearing cycle keeps the flag set.
      if (rollover_clear_i) begin
         d.rov = 1'b0;
      end
      if (running && (q.real_time_counter == `SWIU_REAL_TIME_COUNTER_TOP)) begin
         d.rov = 1'b1;
      end

      // Mode sequencing, interrupt entry and return.
      case (q.mode)
         swiu_pkg::ST_RUN: begin
            if (sleep_exec_i) begin
               d.mode = swiu_pkg::ST_SLEEP;
               if (watchdog_enable_i) begin
                  d.to = 1'b1;
                  d.pd = 1'b0;
               end
            end else if (q.in_isr && ret_any) begin
               d.in_isr     = 1'b0;
               d.int_en     = 1'b1;
               d.restore    = 1'b1;
               d.pc_load    = 1'b1;
               d.pc_val     = q.stack_pc;
               d.fsr_out    = q.sh_fsr;
               d.status_out = q.sh_status;
               d.mode_out   = q.sh_mode;
               d.w_out      = q.sh_w;
               if (interrupt_return_with_add_i) begin
                  // The add replaces this cycle's increment.
                  d.real_time_counter = q.real_time_counter + w_reg_i;
               end
            end else if (irq && int_boundary_i) begin
               d.int_en     = 1'b0;
               d.in_isr     = 1'b1;
               d.int_entry  = 1'b1;
               d.stack_pc   = pc_i;
               d.sh_fsr     = fsr_reg_i;
               d.sh_status  = status_reg_i;
               d.sh_mode    = mode_reg_i;
               d.sh_w       = w_reg_i;
               d.status_out = status_reg_i & ~`SWIU_PAGE_MASK;
               d.fsr_out    = fsr_reg_i;
               d.mode_out   = mode_reg_i;
               d.w_out      = w_reg_i;
               d.pc_load    = 1'b1;
               d.pc_val     = `SWIU_PC_ISR;
            end
         end
         swiu_pkg::ST_SLEEP: begin
            // Any wake source resumes at the reset entry address.
            if (wake) begin
               d.mode    = swiu_pkg::ST_RUN;
               d.pc_load = 1'b1;
               d.pc_val  = `SWIU_PC_TOP;
            end
         end
         default: begin
            d.mode = swiu_pkg::ST_RUN;
         end
      endcase

      // Oscillator stays up in sleep when the fuse bit is cleared.
      d.osc_on = (d.mode == swiu_pkg::ST_RUN) ||
                 !extended_fuse_word_i[`SWIU_FUSE_CLK_BIT];
      d.halt   = (d.mode == swiu_pkg::ST_SLEEP);
   end

   // Register the state; reset masks off every pin and allows interrupts.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q          <= '0;
         q.mode     <= swiu_pkg::ST_RUN;
         q.en       <= `SWIU_MASK_RST;
         q.edge_sel <= `SWIU_MASK_RST;
         q.pend     <= `SWIU_PEND_RST;
         q.int_en   <= 1'b1;
         q.to       <= 1'b1;
         q.pd       <= 1'b1;
         q.osc_on   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign pc_load_o               = q.pc_load;
   assign pc_value_o              = q.pc_val;
   assign int_entry_o             = q.int_entry;
   assign restore_o               = q.restore;
   assign fsr_o                   = q.fsr_out;
   assign status_o                = q.status_out;
   assign mode_o                  = q.mode_out;
   assign w_o                     = q.w_out;
   assign xchg_valid_o            = q.xchg_valid;
   assign xchg_data_o             = q.xchg_data;
   assign wake_enable_mask_o      = q.en;
   assign wake_edge_select_o      = q.edge_sel;
   assign wake_pending_flags_o    = q.pend;
   assign real_time_counter_o     = q.real_time_counter;
   assign counter_rollover_flag_o = q.rov;
   assign timeout_flag_o          = q.to;
   assign power_down_flag_o       = q.pd;
   assign power_down_oscillator_o = q.osc_on;
   assign halt_o                  = q.halt;

endmodule // swiu_top

// file: swiu_top_properties.sv
// Concurrent checks of the sleep, wakeup and interrupt unit at its ports.
`timescale 1ns/10ps
module swiu_top_properties (
   // Clock and reset.
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Inputs watched.
   input wire logic [7:0]  port_b_pins_i,
   input wire logic [11:0] extended_fuse_word_i,
   input wire logic        watchdog_enable_i,
   input wire logic        sleep_exec_i,
   input wire logic        port_wr_i,
   input wire logic [7:0]  mode_reg_i,
   input wire logic [7:0]  w_reg_i,
   input wire logic [7:0]  fsr_reg_i,
   input wire logic [7:0]  status_reg_i,
   input wire logic [11:0] pc_i,
   // Outputs watched.
   input wire logic        pc_load_o,
   input wire logic [11:0] pc_value_o,
   input wire logic        int_entry_o,
   input wire logic        restore_o,
   input wire logic [7:0]  fsr_o,
   input wire logic [7:0]  status_o,
   input wire logic [7:0]  mode_o,
   input wire logic [7:0]  w_o,
   input wire logic        xchg_valid_o,
   input wire logic [7:0]  xchg_data_o,
   input wire logic [7:0]  wake_enable_mask_o,
   input wire logic [7:0]  wake_edge_select_o,
   input wire logic [7:0]  wake_pending_flags_o,
   input wire logic [7:0]  real_time_counter_o,
   input wire logic        counter_rollover_flag_o,
   input wire logic        timeout_flag_o,
   input wire logic        power_down_flag_o,
   input wire logic        power_down_oscillator_o,
   input wire logic        halt_o
);
   logic        busy_q;
   logic [11:0] pc_q;
   logic [7:0]  fsr_q, st_q, md_q, w_q;

   // Remembers the open service routine and the context that its entry saved.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
      end else if (int_entry_o) begin
         busy_q <= 1'b1;
         pc_q <= $past(pc_i);
         fsr_q <= $past(fsr_reg_i);
         st_q <= $past(status_reg_i);
         md_q <= $past(mode_reg_i);
         w_q <= $past(w_reg_i);
      end else if (restore_o) begin
         busy_q <= 1'b0;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // A sleep or a port write that the running core hands over.
   sequence sleep_taken;
      sleep_exec_i && !halt_o;
   endsequence
   sequence run_write(m);
      port_wr_i && mode_reg_i == m && !halt_o;
   endsequence

   a_sleep_halts: assert property (sleep_taken |=> halt_o)
      else $error("Sleep did not halt the core.");
   a_counter_frozen: assert property (halt_o && $past(halt_o) |-> $stable(real_time_counter_o))
      else $error("Counter moved while halted.");
   a_sleep_flags: assert property ((sleep_taken and watchdog_enable_i) |=> timeout_flag_o && !power_down_flag_o)
      else $error("Sleep flags wrong with watchdog on.");
   a_osc_fuse: assert property (sleep_taken |=>
         power_down_oscillator_o == !$past(extended_fuse_word_i[11]))
      else $error("Oscillator state does not follow the fuse.");
   a_wake_pc_top: assert property (halt_o && |(wake_pending_flags_o & ~wake_enable_mask_o) |=>
         !halt_o && pc_load_o && pc_value_o == 12'hFFF)
      else $error("Pin wakeup did not restart at the top address.");
   a_entry_vector: assert property (int_entry_o |-> pc_load_o && pc_value_o == 12'h000 && !busy_q)
      else $error("Bad interrupt entry.");
   a_entry_saves: assert property (int_entry_o |-> fsr_o == $past(fsr_reg_i) && mode_o == $past(mode_reg_i)
         && w_o == $past(w_reg_i) && status_o == ($past(status_reg_i) & 8'h1F))
      else $error("Entry context wrong.");
   a_return_restore: assert property (restore_o |-> pc_load_o && pc_value_o == pc_q && fsr_o == fsr_q
         && status_o == st_q && mode_o == md_q && w_o == w_q)
      else $error("Return context wrong.");
   a_pend_exchange: assert property (run_write(8'h19) |=>
         xchg_valid_o && xchg_data_o == $past(wake_pending_flags_o))
      else $error("Pending exchange wrong.");
   a_edge_write: assert property (run_write(8'h1A) |=> wake_edge_select_o == $past(w_reg_i))
      else $error("Edge select write lost.");
   a_enable_write: assert property (run_write(8'h1B) |=> wake_enable_mask_o == $past(w_reg_i))
      else $error("Enable mask write lost.");
   a_rollover_flag: assert property (real_time_counter_o == 8'h00 && $past(real_time_counter_o) == 8'hFF
         && !restore_o |-> counter_rollover_flag_o)
      else $error("Rollover did not set its flag.");

   // One pending check per pin.
   for (genvar n = 0; n < 8; n++) begin : g_pin
      a_pin_pends: assert property ($changed(port_b_pins_i[n]) && port_b_pins_i[n] != wake_edge_select_o[n]
            ##1 ($stable(port_b_pins_i[n]) && $stable(wake_edge_select_o[n]))[*2]
            |=> wake_pending_flags_o[n])
         else $error("Selected pin edge did not pend.");
   end
endmodule // swiu_top_properties

bind swiu_top swiu_top_properties u_swiu_top_properties (.*);

// file: swiu_pin_model.sv
// Model of the port B pins and the external reset pin outside the unit.
`timescale 1ns/10ps
module swiu_pin_model (
   // Clock.
   input wire logic  clk_i,
   // Pins toward the unit.
   output logic [7:0] port_b_pins_o,
   output logic       external_reset_pin_n_o
);
   // Pins idle high, as pull-ups leave them.
   initial begin
      port_b_pins_o = 8'hFF;
      external_reset_pin_n_o = 1'b1;
   end

   // Sets new levels after a falling edge and holds them for some cycles.
   task automatic drive(input logic [7:0] pins, input logic rst_n, input int hold);
      @(negedge clk_i);
      port_b_pins_o = pins;
      external_reset_pin_n_o = rst_n;
      repeat (hold) @(negedge clk_i);
   endtask
endmodule // swiu_pin_model

// file: sleep_wakeup_interrupt_unit_tb.sv
// Self-checking bench of the sleep, wakeup and interrupt unit.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
`define WAIT_FOR(cond, lim) for (int k = 0; !(cond); k++) begin \
   if (k == lim) begin fail_count++; tally_and_finish(); end else @(negedge clk_i); end
module sleep_wakeup_interrupt_unit_tb;
   logic        clk_i, rst_i, watchdog_enable_i, real_time_counter_int_enable_i, sleep_exec_i, wdt_clear_i;
   logic        int_boundary_i, interrupt_return_i, interrupt_return_with_add_i;
   logic        rollover_clear_i, port_wr_i, external_reset_pin_n_i;
   logic [11:0] extended_fuse_word_i, pc_i, pc_value_o;
   logic [7:0]  mode_reg_i, w_reg_i, fsr_reg_i, status_reg_i, comparator_result_i, port_b_pins_i;
   logic        pc_load_o, int_entry_o, restore_o, xchg_valid_o, counter_rollover_flag_o;
   logic        timeout_flag_o, power_down_flag_o, power_down_oscillator_o, halt_o;
   logic [7:0]  fsr_o, status_o, mode_o, w_o, xchg_data_o, wake_enable_mask_o;
   logic [7:0]  wake_edge_select_o, wake_pending_flags_o, real_time_counter_o;
   logic [7:0]  es, pend, old, r0, wv;
   int          fail_count, checks_done, seed, i, n;

   // Unit under test and the pins around it.
   swiu_top u_swiu_top (.*);
   swiu_pin_model u_swiu_pin_model (.clk_i(clk_i), .port_b_pins_o(port_b_pins_i),
      .external_reset_pin_n_o(external_reset_pin_n_i));

   // A pin edge counts when the new level differs from the falling-edge select bit.
   function automatic logic pin_hit(input logic sel, input logic lvl);
      return lvl != sel;
   endfunction
   // Status as the unit hands it out on entry, page bits dropped.
   function automatic logic [7:0] exp_status(input logic [7:0] st);
      return st & 8'h1F;
   endfunction

   task automatic tally_and_finish();
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One port write from the core; the pending exchange returns the old flags, the comparator exchange its result.
   task automatic port_write(input logic [7:0] m, input logic [7:0] d, output logic [7:0] x);
      port_wr_i = 1'b1;
      mode_reg_i = m;
      w_reg_i = d;
      @(negedge clk_i);
      port_wr_i = 1'b0;
      x = xchg_data_o;
      if (m == 8'h19 || m == 8'h18) `CHK("xchg_valid", 1'b1, xchg_valid_o)
      @(negedge clk_i);
   endtask
   // Single-cycle pulse of sleep, return or clear.
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask

   // Free-running core clock.
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Main sequence.
   initial begin
      {watchdog_enable_i, real_time_counter_int_enable_i, sleep_exec_i, wdt_clear_i, int_boundary_i} = '0;
      {interrupt_return_i, interrupt_return_with_add_i, rollover_clear_i, port_wr_i} = '0;
      {extended_fuse_word_i, pc_i, mode_reg_i, w_reg_i, fsr_reg_i, status_reg_i} = '0;
      fail_count = 0;
      checks_done = 0;
      seed = 32'hf7fc;
      comparator_result_i = 8'($random(seed));
      rst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      rst_i = 1'b0;
      `CHK("enable_mask", 8'hFF, wake_enable_mask_o)
      `CHK("edge_select", 8'hFF, wake_edge_select_o)
      `CHK("halt", 1'b0, halt_o)
      // Edge first, then pending cleared, then enables written; other modes change nothing.
      es = 8'($random(seed));
      port_write(8'h1A, es, old);
      port_write(8'h19, 8'h00, old);
      port_write(8'h18, 8'($random(seed)), old);
      `CHK("comparator_xchg", comparator_result_i, old)
      port_write(8'h1B, 8'hFF, old);
      port_write(8'h07, 8'h00, old);
      `CHK("edge_select", es, wake_edge_select_o)
      `CHK("enable_mask", 8'hFF, wake_enable_mask_o)
      // Random single-pin toggles against random edge selects.
      pend = 8'h00;
      for (i = 0; i < 24; i++) begin
         n = {$random(seed)} % 8;
         wv = port_b_pins_i ^ (8'h01 << n);
         u_swiu_pin_model.drive(wv, 1'b1, 4);
         if (pin_hit(es[n], wv[n])) pend[n] = 1'b1;
         `CHK("pending", pend, wake_pending_flags_o)
      end
      port_write(8'h19, 8'h00, old);
      `CHK("pending_xchg", pend, old)
      // Interrupt from pin 0, a second edge during service, return with add.
      u_swiu_pin_model.drive(8'h00, 1'b1, 4);
      port_write(8'h1A, 8'h00, old);
      port_write(8'h19, 8'h00, old);
      port_write(8'h1B, 8'hFC, old);
      fsr_reg_i = 8'($random(seed));
      status_reg_i = 8'($random(seed));
      pc_i = 12'($random(seed));
      int_boundary_i = 1'b1;
      u_swiu_pin_model.drive(8'h01, 1'b1, 0);
      `WAIT_FOR(int_entry_o, 10)
      `CHK("entry_pc", 12'h000, pc_value_o)
      `CHK("entry_status", exp_status(status_reg_i), status_o)
      `CHK("entry_fsr", fsr_reg_i, fsr_o)
      u_swiu_pin_model.drive(8'h03, 1'b1, 5);
      `CHK("pending_in_service", 8'h03, wake_pending_flags_o)
      `CHK("nested_entry", 1'b0, int_entry_o)
      port_write(8'h19, 8'h02, old);
      wv = 8'($random(seed));
      w_reg_i = wv;
      r0 = real_time_counter_o;
      pulse(interrupt_return_with_add_i);
      `CHK("restore", 1'b1, restore_o)
      `CHK("return_pc", pc_i, pc_value_o)
      `CHK("counter_add", 8'(r0 + wv), real_time_counter_o)
      `WAIT_FOR(int_entry_o, 5)
      port_write(8'h19, 8'h00, old);
      pulse(interrupt_return_i);
      `CHK("restore", 1'b1, restore_o)
      // Counter rollover raises the internal interrupt once enabled.
      pulse(rollover_clear_i);
      `CHK("rollover_flag", 1'b0, counter_rollover_flag_o)
      real_time_counter_int_enable_i = 1'b1;
      `WAIT_FOR(counter_rollover_flag_o, 300)
      `WAIT_FOR(int_entry_o, 5)
      pulse(rollover_clear_i);
      pulse(interrupt_return_i);
      real_time_counter_int_enable_i = 1'b0;
      int_boundary_i = 1'b0;
      // Sleep with the oscillator kept on; a pin edge wakes to the top address.
      u_swiu_pin_model.drive(8'h00, 1'b1, 4);
      pulse(sleep_exec_i);
      `CHK("halt", 1'b1, halt_o)
      `CHK("osc_on", 1'b1, power_down_oscillator_o)
      r0 = real_time_counter_o;
      repeat (5) @(negedge clk_i);
      `CHK("counter_frozen", r0, real_time_counter_o)
      u_swiu_pin_model.drive(8'h02, 1'b1, 0);
      `WAIT_FOR(!halt_o, 8)
      `CHK("wake_pc", 12'hFFF, pc_value_o)
      `CHK("wake_load", 1'b1, pc_load_o)
      port_write(8'h19, 8'h00, old);
      // Sleep with the watchdog on; its overflow ends the sleep.
      extended_fuse_word_i = 12'h800;
      watchdog_enable_i = 1'b1;
      pulse(sleep_exec_i);
      `CHK("timeout_flag", 1'b1, timeout_flag_o)
      `CHK("power_down_flag", 1'b0, power_down_flag_o)
      `CHK("osc_on", 1'b0, power_down_oscillator_o)
      `WAIT_FOR(!halt_o, 26000)
      `CHK("wake_pc", 12'hFFF, pc_value_o)
      // Sleep ended by the external reset pin.
      watchdog_enable_i = 1'b0;
      pulse(sleep_exec_i);
      u_swiu_pin_model.drive(8'h02, 1'b0, 0);
      `WAIT_FOR(!halt_o, 8)
      `CHK("rst_wake_pc", 12'hFFF, pc_value_o)
      u_swiu_pin_model.drive(8'h02, 1'b1, 4);
      tally_and_finish();
   end
endmodule // sleep_wakeup_interrupt_unit_tb
